// ==== sim/core_bus_model.sv ====
`timescale 1ns/10ps
module core_bus_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] ioRdData,
  input  wire logic       cpuStall,
  output logic      [6:0] busAddr,
  output logic            busIsData,
  output logic            ioWe,
  output logic            ioRe,
  output logic      [7:0] ioWrData,
  output logic            bitSet,
  output logic            bitClr,
  output logic      [2:0] bitIdx
);
  localparam logic [6:0] A_CTRL = 7'h10;

  // Bus parks idle with no strobe
  initial
  begin
    busAddr = 7'h00;
    busIsData = 1'b0;
    ioWe = 1'b0;
    ioRe = 1'b0;
    ioWrData = 8'h00;
    bitSet = 1'b0;
    bitClr = 1'b0;
    bitIdx = 3'h0;
  end

  // Core cannot issue while stalled; checked just past the edge
  task automatic hold_off();
    #1;
    while (cpuStall === 1'b1)
      @(posedge sys_clk) #1;
    @(posedge sys_clk);
  endtask

  // One register write; returns at the edge that takes it
  task automatic io_write(input logic [6:0] a, input logic [7:0] d,
                          input logic isData);
    hold_off();
    busAddr <= a;
    busIsData <= isData;
    ioWrData <= d;
    ioWe <= 1'b1;
    @(posedge sys_clk);
    ioWe <= 1'b0;
    ioWrData <= ~d; // Stale data is not left on the bus
  endtask

  // One register read; data taken one cycle after the request
  task automatic io_read(input logic [6:0] a, input logic isData,
                         output logic [7:0] d);
    hold_off();
    busAddr <= a;
    busIsData <= isData;
    ioRe <= 1'b1;
    @(posedge sys_clk);
    ioRe <= 1'b0;
    #1;
    d = ioRdData;
  endtask

  // Single-bit set or clear pulse
  task automatic bit_op(input logic [6:0] a, input logic [2:0] i,
                        input logic setNotClr);
    hold_off();
    busAddr <= a;
    busIsData <= 1'b0;
    bitIdx <= i;
    bitSet <= setNotClr;
    bitClr <= ~setNotClr;
    @(posedge sys_clk);
    bitSet <= 1'b0;
    bitClr <= 1'b0;
  endtask

  task automatic store_byte(input logic [8:0] ea, input logic [7:0] d,
                            input logic rie);
    logic [7:0] v;
    int         n;
    v = 8'hFF;
    n = 0;
    while (v[1] !== 1'b0 && n < 400)
    begin
      io_read(A_CTRL, 1'b0, v);
      n++;
    end
    io_write(7'h13, {7'h00, ea[8]}, 1'b0);
    io_write(7'h12, ea[7:0], 1'b0);
    io_write(7'h11, d, 1'b0);
    // Arm and strobe back to back, no gap for an interrupt
    io_write(A_CTRL, {4'h0, rie, 3'b100}, 1'b0);
    io_write(A_CTRL, {4'h0, rie, 3'b110}, 1'b0);
  endtask
endmodule

// ==== sim/eeprom_access_control_test.sv ====
`timescale 1ns/10ps
module eeprom_access_control_test;
  localparam int         WOC    = 8;
  localparam logic [6:0] A_CTRL = 7'h10;
  localparam logic [6:0] A_DATA = 7'h11;
  localparam logic [6:0] A_ALO  = 7'h12;
  localparam logic [6:0] A_AHI  = 7'h13;

  logic       sys_clk;
  logic       sys_rst;
  logic       pwrOnRst;
  logic       oscClk;
  logic       globalIrqEn;
  logic       self_program_active;
  logic       sleepPowerDown;
  logic [6:0] busAddr;
  logic       busIsData;
  logic       ioWe;
  logic       ioRe;
  logic [7:0] ioWrData;
  logic       bitSet;
  logic       bitClr;
  logic [2:0] bitIdx;
  logic [7:0] ioRdData;
  logic       cpuStall;
  logic       readyIrq;
  logic       oscKeepAlive;
  logic       powerDownOk;
  int         mismatches;
  int         check_count;
  int         tStart;

  eeprom_access_control #(.WriteOscCycles(WOC)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pwrOnRst(pwrOnRst),
    .busAddr(busAddr), .busIsData(busIsData), .ioWe(ioWe), .ioRe(ioRe),
    .ioWrData(ioWrData), .bitSet(bitSet), .bitClr(bitClr),
    .bitIdx(bitIdx), .ioRdData(ioRdData), .cpuStall(cpuStall),
    .globalIrqEn(globalIrqEn), .readyIrq(readyIrq),
    .self_program_active(self_program_active), .oscClk(oscClk),
    .sleepPowerDown(sleepPowerDown), .oscKeepAlive(oscKeepAlive),
    .powerDownOk(powerDownOk));

  core_bus_model core (
    .sys_clk(sys_clk), .ioRdData(ioRdData), .cpuStall(cpuStall),
    .busAddr(busAddr), .busIsData(busIsData), .ioWe(ioWe), .ioRe(ioRe),
    .ioWrData(ioWrData), .bitSet(bitSet), .bitClr(bitClr),
    .bitIdx(bitIdx));

  // System clock, 10 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Timing oscillator, slow and off phase from the system clock
  initial
  begin
    oscClk = 1'b0;
    #3;
    forever #40 oscClk = ~oscClk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    core.io_read(a, 1'b0, v);
    check(v, exp);
  endtask

  // Count stalled cycles over a fixed window
  task automatic stall_len(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (8)
    begin
      #1;
      if (cpuStall === 1'b1)
        n++;
      @(posedge sys_clk);
    end
    check(n, exp);
  endtask

  // Poll busy flag with a bound
  task automatic wait_idle();
    logic [7:0] v;
    int         n;
    v = 8'hFF;
    n = 0;
    while (v[1] !== 1'b0 && n < 300)
    begin
      core.io_read(A_CTRL, 1'b0, v);
      n++;
    end
    check(v & 8'h02, 8'h00);
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog, far above the expected run
  initial
  begin
    #100us;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    mismatches = 0;
    check_count = 0;
    sys_rst = 1'b1;
    pwrOnRst = 1'b1;
    globalIrqEn = 1'b0;
    self_program_active = 1'b0;
    sleepPowerDown = 1'b0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    pwrOnRst <= 1'b0;
    core.io_write(A_CTRL, 8'hF0, 1'b0);
    rd_chk(A_CTRL, 8'h00);
    core.io_write(A_AHI, 8'hFF, 1'b0);
    rd_chk(A_AHI, 8'h01);
    core.io_write(A_CTRL, 8'h02, 1'b0);
    rd_chk(A_CTRL, 8'h00);
    core.io_write(A_CTRL, 8'h04, 1'b0);
    rd_chk(A_CTRL, 8'h04);
    repeat (4) @(posedge sys_clk);
    rd_chk(A_CTRL, 8'h00);
    core.io_write(A_CTRL, 8'h02, 1'b0);
    rd_chk(A_CTRL, 8'h00);
    // Flash programming blocks the start
    @(posedge sys_clk) self_program_active <= 1'b1;
    core.store_byte(9'h033, 8'hC3, 1'b0);
    // Strobe write re-armed; busy must stay clear
    rd_chk(A_CTRL, 8'h04);
    @(posedge sys_clk) self_program_active <= 1'b0;
    globalIrqEn <= 1'b1;
    // Timed write with the ready interrupt enabled
    core.store_byte(9'h1A5, 8'h5A, 1'b1);
    tStart = $time;
    stall_len(8'h02);
    rd_chk(A_CTRL, 8'h0A);
    check({7'h00, readyIrq}, 8'h00);
    core.io_write(A_ALO, 8'h00, 1'b0);
    rd_chk(A_ALO, 8'hA5);
    core.bit_op(A_CTRL, 3'h0, 1'b1);
    rd_chk(A_DATA, 8'h5A);
    @(posedge sys_clk) sleepPowerDown <= 1'b1;
    #1;
    check({6'h00, oscKeepAlive, powerDownOk}, 8'h02);
    wait_idle();
    check({7'h00, ($time - tStart) / 10 >= (WOC - 1) * 8}, 8'h01);
    check({6'h00, readyIrq, powerDownOk}, 8'h03);
    @(posedge sys_clk) globalIrqEn <= 1'b0;
    sleepPowerDown <= 1'b0;
    #1;
    check({7'h00, readyIrq}, 8'h00);
    core.io_write(A_CTRL, 8'h01, 1'b0);
    stall_len(8'h04);
    rd_chk(A_DATA, 8'h5A);
    // System reset in mid-write must not abort it
    core.store_byte(9'h0F0, 8'h3C, 1'b0);
    @(posedge sys_clk) sys_rst <= 1'b1;
    @(posedge sys_clk) sys_rst <= 1'b0;
    rd_chk(A_CTRL, 8'h02);
    wait_idle();
    core.io_write(A_ALO + 7'h20, 8'hF0, 1'b1);
    core.io_write(A_CTRL + 7'h20, 8'h01, 1'b1);
    rd_chk(A_DATA, 8'h3C);
    core.io_write(A_AHI, 8'h01, 1'b0);
    core.io_write(A_ALO, 8'hA5, 1'b0);
    core.io_write(A_CTRL, 8'h01, 1'b0);
    rd_chk(A_DATA, 8'h5A);
    core.bit_op(A_CTRL, 3'h3, 1'b1);
    rd_chk(A_CTRL, 8'h08);
    core.bit_op(A_CTRL, 3'h3, 1'b0);
    rd_chk(A_CTRL, 8'h00);
    give_verdict();
  end
endmodule

// ==== src/eeprom_access_control.sv ====
// Functional notes
// - Control register bits 7..4 always read back as zero.
// - Ready interrupt is a level while enabled, global enabled, strobe clear.
// - Write starts only when strobe is set while the arm bit is still set.
// - Hardware drops the arm bit four clocks after software sets it.
// - Strobe set with arm bit clear starts nothing.
// - No array write starts while the core programs flash.
// - Hardware clears the write strobe when the write time has elapsed.
// - Starting a write stalls the core for two cycles; an unarmed or blocked strobe does not stall.
// - Read strobe loads the addressed byte into the data register at once.
// - A read stalls the core for four cycles.
// - During a write, reads are ignored and the address stays frozen.
// - Each write lasts 8448 calibrated oscillator cycles.
// - Power-down keeps the write and its oscillator running to the end.
// - System reset does not abort a write in progress.
// - Single-bit set and clear work on addresses 0x00 to 0x1F only.
// - Port addresses direct; data-space addresses sit 0x20 higher.
// - Bit instructions rewrite the whole register read back.
// - Address register holds nine bits; upper bits read zero.
// - Data register feeds writes and receives read bytes.
`timescale 1ns/10ps
module eeprom_access_control #(
  parameter int WriteOscCycles = eeprom_access_pkg::WRITE_OSC_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       pwrOnRst,
  input  wire logic [6:0] busAddr,
  input  wire logic       busIsData,
  input  wire logic       ioWe,
  input  wire logic       ioRe,
  input  wire logic [7:0] ioWrData,
  input  wire logic       bitSet,
  input  wire logic       bitClr,
  input  wire logic [2:0] bitIdx,
  output logic      [7:0] ioRdData,
  output logic            cpuStall,
  input  wire logic       globalIrqEn,
  output logic            readyIrq,
  input  wire logic       self_program_active,
  input  wire logic       oscClk,
  input  wire logic       sleepPowerDown,
  output logic            oscKeepAlive,
  output logic            powerDownOk
);

  logic [7:0]  mem [eeprom_access_pkg::ARR_DEPTH];
  logic        ready_irq_enable_ff;
  logic        master_write_arm_ff;
  logic [2:0]  armCnt_ff;
  logic [7:0]  nv_data_reg_ff;
  logic [8:0]  nv_address_reg_ff;
  logic [2:0]  stallCnt_ff;
  logic [7:0]  ioRdData_ff;

  eeprom_access_pkg::engine_e engState_ff;
  logic [eeprom_access_pkg::OSC_CNT_W-1:0] oscCnt_ff;
  logic [8:0]  latAddr_ff;
  logic [7:0]  latData_ff;
  logic        oscSync1_ff;
  logic        oscSync2_ff;
  logic        oscPrev_ff;

  logic [6:0]  effAddr;
  logic        inRange;
  logic        bitOp;
  logic        wrEn;
  logic [7:0]  wrVal;
  logic [7:0]  rdVal;
  logic        ctrlWr;
  logic        dataWr;
  logic        addrLoWr;
  logic        addrHiWr;
  logic        write_strobe;
  logic        wsReq;
  logic        startWrite;
  logic        startRead;
  logic        armWrite;
  logic        oscRise;
  logic        lastOsc;
  logic [7:0]  memRdByte;

  localparam logic [eeprom_access_pkg::OSC_CNT_W-1:0] OSC_LAST =
    eeprom_access_pkg::OSC_CNT_W'(WriteOscCycles - 1);

  // Port addresses pass as is; data-space addresses lose the offset
  function automatic logic [6:0] io_address(input logic [6:0] addr,
                                            input logic       isData);
    io_address = isData ? 7'(addr - eeprom_access_pkg::DS_OFFSET) : addr;
  endfunction

  // Read view of one register; unmapped addresses read zero
  function automatic logic [7:0] reg_view(input logic [6:0] addr,
                                          input logic       rie,
                                          input logic       arm,
                                          input logic       busy,
                                          input logic [7:0] data,
                                          input logic [8:0] ea);
    reg_view = 8'h00;
    if (addr == {1'b0, eeprom_access_pkg::IO_CTRL})
      reg_view = {eeprom_access_pkg::CTRL_RSVD, rie, arm, busy, 1'b0};
    else if (addr == {1'b0, eeprom_access_pkg::IO_DATA})
      reg_view = data;
    else if (addr == {1'b0, eeprom_access_pkg::IO_ADDR_LO})
      reg_view = ea[7:0];
    else if (addr == {1'b0, eeprom_access_pkg::IO_ADDR_HI})
      reg_view = {7'h00, ea[8]};
  endfunction

  assign effAddr = io_address(busAddr, busIsData);
  assign inRange = effAddr <= {1'b0, eeprom_access_pkg::IO_RANGE_TOP};

  assign write_strobe = engState_ff != eeprom_access_pkg::ENG_IDLE;
  // reserved control bits in the read view
  assign rdVal = reg_view(effAddr, ready_irq_enable_ff, master_write_arm_ff,
                          write_strobe, nv_data_reg_ff, nv_address_reg_ff);

  // bit operations ignored above the low range
  assign bitOp = (bitSet | bitClr) & ~ioWe
               & (effAddr <= {1'b0, eeprom_access_pkg::BIT_RANGE_TOP});
  assign wrEn  = (ioWe & inRange) | bitOp;

  always_comb
  begin
    wrVal = ioWrData;
    if (bitOp)
    begin
      wrVal = rdVal;
      wrVal[bitIdx] = bitSet;
    end
  end

  assign ctrlWr   = wrEn & (effAddr == {1'b0, eeprom_access_pkg::IO_CTRL});
  assign dataWr   = wrEn & (effAddr == {1'b0, eeprom_access_pkg::IO_DATA});
  assign addrLoWr = wrEn & (effAddr == {1'b0, eeprom_access_pkg::IO_ADDR_LO});
  assign addrHiWr = wrEn & (effAddr == {1'b0, eeprom_access_pkg::IO_ADDR_HI});

  assign wsReq    = ctrlWr & wrVal[eeprom_access_pkg::CTRL_WS];
  assign armWrite = ctrlWr & wrVal[eeprom_access_pkg::CTRL_ARM];

  // strobe counts only inside the armed window
  assign startWrite = wsReq & master_write_arm_ff & ~write_strobe
                    & ~self_program_active;

  // reads ignored while a write runs
  assign startRead = ctrlWr & wrVal[eeprom_access_pkg::CTRL_RS]
                   & ~write_strobe;
  assign memRdByte = mem[nv_address_reg_ff];

  // Interrupt enable
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ready_irq_enable_ff <= 1'b0;
    else if (ctrlWr)
      ready_irq_enable_ff <= wrVal[eeprom_access_pkg::CTRL_RIE];
  end

  // arm bit times out after four clocks
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      master_write_arm_ff <= 1'b0;
      armCnt_ff           <= 3'h0;
    end
    else if (armWrite)
    begin
      master_write_arm_ff <= 1'b1;
      armCnt_ff           <= eeprom_access_pkg::ARM_CYCLES;
    end
    else if (armCnt_ff != 3'h0)
    begin
      armCnt_ff <= armCnt_ff - 3'h1;
      if (armCnt_ff == 3'h1)
        master_write_arm_ff <= 1'b0;
    end
  end

  // data register, written by software or by a read
  // read byte lands on the next edge
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      nv_data_reg_ff <= eeprom_access_pkg::DATA_RST;
    else if (startRead)
      nv_data_reg_ff <= memRdByte;
    else if (dataWr)
      nv_data_reg_ff <= wrVal;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      nv_address_reg_ff <= eeprom_access_pkg::ADDR_RST;
    else if (!write_strobe)
    begin
      if (addrLoWr)
        nv_address_reg_ff[7:0] <= wrVal;
      else if (addrHiWr)
        nv_address_reg_ff[8] <= wrVal[0];
    end
  end

  // Core stall counter
  // two cycles after a write start, four after a read start
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      stallCnt_ff <= 3'h0;
    else if (startWrite)
      stallCnt_ff <= eeprom_access_pkg::WR_STALL;
    else if (startRead)
      stallCnt_ff <= eeprom_access_pkg::RD_STALL;
    else if (stallCnt_ff != 3'h0)
      stallCnt_ff <= stallCnt_ff - 3'h1;
  end

  assign cpuStall = stallCnt_ff != 3'h0;

  // Registered read data, one cycle after the read request
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ioRdData_ff <= 8'h00;
    else if (ioRe)
      ioRdData_ff <= rdVal;
  end

  assign ioRdData = ioRdData_ff;

  // oscillator edges through two flops before use
  // only power-on reset touches the write side
  always_ff @(posedge sys_clk or posedge pwrOnRst)
  begin
    if (pwrOnRst)
    begin
      oscSync1_ff <= 1'b0;
      oscSync2_ff <= 1'b0;
      oscPrev_ff  <= 1'b0;
    end
    else
    begin
      oscSync1_ff <= oscClk;
      oscSync2_ff <= oscSync1_ff;
      oscPrev_ff  <= oscSync2_ff;
    end
  end

  assign oscRise = oscSync2_ff & ~oscPrev_ff;
  assign lastOsc = oscRise & (oscCnt_ff == OSC_LAST);

  // system reset leaves a running write alone
  always_ff @(posedge sys_clk or posedge pwrOnRst)
  begin
    if (pwrOnRst)
    begin
      engState_ff <= eeprom_access_pkg::ENG_IDLE;
      oscCnt_ff   <= '0;
      latAddr_ff  <= eeprom_access_pkg::ADDR_RST;
      latData_ff  <= eeprom_access_pkg::DATA_RST;
    end
    else
    begin
      unique case (engState_ff)
        eeprom_access_pkg::ENG_IDLE:
          if (startWrite)
          begin
            engState_ff <= eeprom_access_pkg::ENG_BUSY;
            oscCnt_ff   <= '0;
            latAddr_ff  <= nv_address_reg_ff;
            latData_ff  <= nv_data_reg_ff;
          end
        eeprom_access_pkg::ENG_BUSY:
          if (lastOsc)
            engState_ff <= eeprom_access_pkg::ENG_DONE;
          else if (oscRise)
            oscCnt_ff <= oscCnt_ff + 1'b1;
        // strobe clears after the commit cycle
        eeprom_access_pkg::ENG_DONE:
          engState_ff <= eeprom_access_pkg::ENG_IDLE;
        default:
          engState_ff <= eeprom_access_pkg::ENG_IDLE;
      endcase
    end
  end

  // array has no reset; written only at completion
  always_ff @(posedge sys_clk)
  begin
    if (engState_ff == eeprom_access_pkg::ENG_BUSY && lastOsc)
      mem[latAddr_ff] <= latData_ff;
  end

  // level interrupt while the strobe reads clear
  assign readyIrq = ready_irq_enable_ff & globalIrqEn & ~write_strobe;

  // a running write keeps the oscillator alive through sleep
  assign oscKeepAlive = write_strobe;
  assign powerDownOk  = sleepPowerDown & ~write_strobe;

  // Checks on the core-facing behaviour
  a_arm_timeout: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(master_write_arm_ff) ##1 (!armWrite)[*3] |=> !master_write_arm_ff)
    else $error("arm bit did not time out after four clocks");
  a_unarmed_strobe: assert property (
    @(posedge sys_clk) disable iff (sys_rst || pwrOnRst)
    (wsReq && !master_write_arm_ff && !write_strobe) |=> !write_strobe)
    else $error("unarmed strobe started a write");
  a_armed_start: assert property (
    @(posedge sys_clk) disable iff (sys_rst || pwrOnRst)
    (wsReq && master_write_arm_ff && !write_strobe && !self_program_active)
      |=> write_strobe && engState_ff == eeprom_access_pkg::ENG_BUSY)
    else $error("armed strobe did not start a write");
  a_flash_block: assert property (
    @(posedge sys_clk) disable iff (sys_rst || pwrOnRst)
    (self_program_active && !write_strobe) |=> !write_strobe)
    else $error("write started during flash programming");
  a_write_stall: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    startWrite |=> cpuStall[*2] ##1 !cpuStall)
    else $error("write stall not two cycles");
  a_read_stall: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    startRead |=> cpuStall[*4] ##1 !cpuStall)
    else $error("read stall not four cycles");
  a_read_data: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    startRead |=> nv_data_reg_ff == $past(memRdByte))
    else $error("read byte not loaded into data register");
  a_addr_frozen: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    write_strobe |=> $stable(nv_address_reg_ff))
    else $error("address changed during a write");
  a_ctrl_reserved: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $past(ioRe && effAddr == {1'b0, eeprom_access_pkg::IO_CTRL})
      |-> ioRdData[7:4] == eeprom_access_pkg::CTRL_RSVD)
    else $error("reserved control bits read nonzero");
  a_strobe_clear: assert property (
    @(posedge sys_clk) disable iff (pwrOnRst)
    engState_ff == eeprom_access_pkg::ENG_DONE |=> !write_strobe)
    else $error("strobe not cleared after write time");
  // Two separate implications; unbracketed they would nest and misfire
  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ((ready_irq_enable_ff && globalIrqEn && !write_strobe) |-> readyIrq)
      and (write_strobe |-> !readyIrq))
    else $error("ready interrupt level wrong");

endmodule

// ==== src/eeprom_access_pkg.sv ====
package eeprom_access_pkg;

  // I/O addresses of the access registers (port space)
  localparam logic [5:0] IO_CTRL       = 6'h10;
  localparam logic [5:0] IO_DATA       = 6'h11;
  localparam logic [5:0] IO_ADDR_LO    = 6'h12;
  localparam logic [5:0] IO_ADDR_HI    = 6'h13;

  // Data-space view sits this far above the port addresses
  localparam logic [6:0] DS_OFFSET     = 7'h20;
  // Top address reachable by single-bit instructions
  localparam logic [5:0] BIT_RANGE_TOP = 6'h1F;
  // Top address of the whole I/O space
  localparam logic [5:0] IO_RANGE_TOP  = 6'h3F;

  // Control register field positions
  localparam int CTRL_RIE  = 3;
  localparam int CTRL_ARM  = 2;
  localparam int CTRL_WS   = 1;
  localparam int CTRL_RS   = 0;
  localparam logic [3:0] CTRL_RSVD = 4'h0;

  // Reset values
  localparam logic [7:0] DATA_RST      = 8'h00;
  localparam logic [8:0] ADDR_RST      = 9'h000;

  // Array geometry
  localparam int ADDR_W    = 9;
  localparam int ARR_DEPTH = 512;

  // Core-side timing in CPU clock cycles
  localparam logic [2:0] ARM_CYCLES    = 3'h4;
  localparam logic [2:0] WR_STALL      = 3'h2;
  localparam logic [2:0] RD_STALL      = 3'h4;

  // Write timing from the calibrated oscillator
  localparam int OSC_FREQ_HZ      = 1_000_000;
  localparam int WRITE_OSC_CYCLES = 8448;
  localparam int WRITE_TIME_US    = 8500;
  localparam int OSC_CNT_W        = 14;

  // Write engine states
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_BUSY = 3'b010,
    ENG_DONE = 3'b100
  } engine_e;

endpackage
